// file: logic/fsc_ctrl.sv
// host controller for flash command, status and protection
`timescale 1ns/1ps
module fsc_ctrl
  import fsc_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // flash control pins
  output logic             CE_N,
  output logic             OE_N,
  output logic             WE_N,
  output logic             RESET_POWERDOWN_IN_N,
  output logic             WP_N,
  input  wire logic        READY_BUSY_OUT,
  // flash address and data
  output logic [19:0]      FL_ADDR,
  input  wire logic [15:0] DQ_I,
  output logic [15:0]      DQ_O,
  output logic             DQ_OE
);
  import fsc_pkg::*;

  typedef enum logic [6:0] {
    SQ_IDLE  = 7'b0000001,  // waiting for go
    SQ_CMD1  = 7'b0000010,  // first command write
    SQ_CMD2  = 7'b0000100,  // confirm or data write
    SQ_POLLC = 7'b0001000,  // write read-status command
    SQ_POLLR = 7'b0010000,  // read status
    SQ_TAIL  = 7'b0100000,  // trailing read-array command
    SQ_READ  = 7'b1000000   // read one array word
  } fsc_sq_e;

  fsc_cyc_if cyc ();         // link to pin engine

  fsc_sq_e     st, next_st;          // sequencer state
  logic [2:0]  op, next_op;          // operation in progress
  logic [19:0] tgt, next_tgt;        // target address
  logic [15:0] dat, next_dat;        // write data / read result
  logic [7:0]  stat, next_stat;      // last status byte read
  logic [1:0]  res, next_res;        // result code
  logic        rst_ctl, next_rst_ctl;  // hold device in reset
  logic        wp_ctl, next_wp_ctl;    // hold write protect low
  logic        ack, next_ack;          // bus acknowledge
  logic [31:0] rdo, next_rdo;          // bus read data
  logic        req, next_req;          // pin cycle request
  logic        cwr, next_cwr;          // pin cycle direction
  logic [15:0] cwd, next_cwd;          // pin cycle data
  logic        go;                     // software start strobe
  logic        busy;                   // sequencer active

  // setup code of a data-changing operation
  function automatic logic [7:0] setup_code(input logic [2:0] o);
    case (o)
      OP_CLEAR_LOCKS: setup_code = CMD_LOCK_SETUP;
      OP_SET_LOCK:    setup_code = CMD_LOCK_SETUP;
      OP_ERASE:       setup_code = CMD_ERASE_SETUP;
      OP_WRITE:       setup_code = CMD_WRITE_SETUP;
      OP_CLEAR:       setup_code = CMD_CLEAR;
      OP_READ_ARRAY:  setup_code = CMD_READ_ARRAY;
      default:        setup_code = CMD_READ_STATUS;
    endcase
  endfunction : setup_code

  // error bits seen in a status byte
  function automatic logic has_error(input logic [7:0] s);
    has_error = s[SR_ERASE] | s[SR_WRITE] | s[SR_SUPPLY] | s[SR_PROT];
  endfunction : has_error

  assign busy = (st != SQ_IDLE);
  assign go = WB_CYC_I && WB_STB_I && WB_WE_I && !ack && WB_SEL_I[0]
              && (WB_ADR_I == REG_CTRL) && WB_DAT_I[CTRL_GO_BIT] && !busy
              && !rst_ctl;

  assign cyc.req   = req;
  assign cyc.wr    = cwr;
  assign cyc.addr  = tgt;
  assign cyc.wdata = cwd;

  // bus slave: one wait state, ack for every address, unmapped reads zero
  always_comb begin
    next_ack = WB_CYC_I && WB_STB_I && !ack;
    next_rdo = 32'h00000000;
    next_rst_ctl = rst_ctl;
    next_wp_ctl = wp_ctl;
    if (WB_CYC_I && WB_STB_I && !ack) begin
      if (WB_WE_I) begin
        if (WB_ADR_I == REG_CTRL && WB_SEL_I[1]) begin
          next_rst_ctl = WB_DAT_I[CTRL_RST_BIT];
          next_wp_ctl  = WB_DAT_I[CTRL_WP_BIT];
        end
      end else begin
        case (WB_ADR_I)
          // busy sits at bit 5, beside the go bit at 4
          REG_CTRL:   next_rdo = {22'h0, wp_ctl, rst_ctl, 2'h0, busy,
                                  2'h0, op};
          REG_ADDR:   next_rdo = {12'h000, tgt};
          REG_DATA:   next_rdo = {16'h0000, dat};
          REG_STATUS: next_rdo = {23'h0, READY_BUSY_OUT, stat};
          REG_RESULT: next_rdo = {30'h0, res};
          default:    next_rdo = 32'h00000000;
        endcase
      end
    end
  end

  // sequencer: lock, erase and write ops run setup, confirm, poll until ready, then read-array
  always_comb begin
    next_st = st; next_op = op; next_tgt = tgt; next_dat = dat;
    next_stat = stat; next_res = res;
    next_req = 1'b0; next_cwr = cwr; next_cwd = cwd;
    if (!busy && WB_CYC_I && WB_STB_I && WB_WE_I && !ack) begin
      if (WB_ADR_I == REG_ADDR) next_tgt = WB_DAT_I[19:0];
      if (WB_ADR_I == REG_DATA) next_dat = WB_DAT_I[15:0];
    end
    case (st)
      SQ_IDLE: begin
        if (go) begin
          next_op = WB_DAT_I[CTRL_OP_LSB +: 3];
          next_res = RES_OK;
          if (WB_DAT_I[CTRL_OP_LSB +: 3] == OP_READ_WORD) begin
            next_st = SQ_READ; next_req = 1'b1; next_cwr = 1'b0;
          end else begin
            next_st = SQ_CMD1; next_req = 1'b1; next_cwr = 1'b1;
            next_cwd = {8'h00, setup_code(WB_DAT_I[CTRL_OP_LSB +: 3])};
          end
        end
      end
      SQ_CMD1: begin
        if (cyc.done) begin
          if (op >= OP_CLEAR_LOCKS) begin
            // second write confirms the change
            next_st = SQ_CMD2; next_req = 1'b1; next_cwr = 1'b1;
            case (op)
              OP_SET_LOCK: next_cwd = {8'h00, CMD_LOCK_SET};
              OP_WRITE:    next_cwd = dat;
              default:     next_cwd = {8'h00, CMD_CONFIRM};
            endcase
          end else if (op == OP_READ_STATUS) begin
            next_st = SQ_POLLR; next_req = 1'b1; next_cwr = 1'b0;
          end else begin
            next_st = SQ_IDLE;
          end
        end
      end
      SQ_CMD2: begin
        if (cyc.done) begin
          next_st = SQ_POLLR; next_req = 1'b1; next_cwr = 1'b0;
        end
      end
      SQ_POLLC: begin
        if (cyc.done) begin
          next_st = SQ_POLLR; next_req = 1'b1; next_cwr = 1'b0;
        end
      end
      SQ_POLLR: begin
        if (cyc.done) begin
          next_stat = cyc.rdata[7:0];
          if (!cyc.rdata[SR_READY]) begin
            // machine still busy, poll again
            next_req = 1'b1; next_cwr = 1'b0;
          end else begin
            if (has_error(cyc.rdata[7:0])) next_res = RES_ERROR;
            if (op >= OP_CLEAR_LOCKS) begin
              // return device to array reads
              next_st = SQ_TAIL; next_req = 1'b1; next_cwr = 1'b1;
              next_cwd = {8'h00, CMD_READ_ARRAY};
            end else next_st = SQ_IDLE;
          end
        end
      end
      SQ_TAIL: if (cyc.done) next_st = SQ_IDLE;
      SQ_READ: begin
        if (cyc.done) begin
          next_dat = cyc.rdata; next_st = SQ_IDLE;
        end
      end
      default: next_st = SQ_IDLE;
    endcase
  end

  // registers; device reset abandons the sequence
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st <= SQ_IDLE; op <= OP_READ_STATUS; tgt <= 20'h00000;
      dat <= 16'h0000; stat <= 8'h00; res <= RES_OK;
      rst_ctl <= 1'b1; wp_ctl <= 1'b1; ack <= 1'b0;
      rdo <= 32'h00000000; req <= 1'b0; cwr <= 1'b0; cwd <= 16'h0000;
    end else begin
      st <= (rst_ctl && st != SQ_IDLE) ? SQ_IDLE : next_st;
      op <= next_op; tgt <= next_tgt; dat <= next_dat;
      stat <= rst_ctl ? 8'h00 : next_stat;
      res <= next_res; rst_ctl <= next_rst_ctl; wp_ctl <= next_wp_ctl;
      ack <= next_ack; rdo <= next_rdo;
      req <= rst_ctl ? 1'b0 : next_req;
      cwr <= next_cwr; cwd <= next_cwd;
    end
  end

  // pin cycle engine, chip enable only for our cycles
  fsc_pin_cycle u_pin (
    .clk    (CORE_CLK),
    .rst_n  (RST_N),
    .cyc    (cyc.engine),
    .ce_n   (CE_N),
    .oe_n   (OE_N),
    .we_n   (WE_N),
    .addr   (FL_ADDR),
    .dq_in  (DQ_I),
    .dq_out (DQ_O),
    .dq_oe  (DQ_OE)
  );

  assign RESET_POWERDOWN_IN_N = ~rst_ctl;
  assign WP_N = ~wp_ctl;
  assign WB_ACK_O = ack;
  assign WB_DAT_O = rdo;

  AST_ACK_ONE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");
  AST_RESET_IDLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    rst_ctl |=> ##1 (st == SQ_IDLE)) else $error("busy in reset");
  AST_STAT_CLR: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    rst_ctl |=> (stat == 8'h00)) else $error("status kept");
  AST_TAIL: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st == SQ_POLLR && cyc.done && cyc.rdata[SR_READY]
     && op >= OP_CLEAR_LOCKS && !rst_ctl) |=> (st == SQ_TAIL
     && cwd[7:0] == CMD_READ_ARRAY)) else $error("no read-array");
  AST_CONFIRM: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st == SQ_CMD1 && cyc.done && op >= OP_CLEAR_LOCKS && !rst_ctl)
    |=> (st == SQ_CMD2)) else $error("no confirm write");
  AST_ERR: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st == SQ_POLLR && cyc.done && cyc.rdata[SR_READY]
     && has_error(cyc.rdata[7:0])) |=> (res == RES_ERROR))
    else $error("error missed");
  AST_NO_WR_RST: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(rst_ctl) |-> ##[1:40] WE_N) else $error("write in reset");
  AST_WP: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    WP_N == !wp_ctl) else $error("wp mismatch");
endmodule : fsc_ctrl

// file: logic/fsc_cyc_if.sv
// interface between sequencer and pin cycle engine
`timescale 1ns/1ps
interface fsc_cyc_if;
  logic        req;    // start one pin cycle
  logic        wr;     // one = write, zero = read
  logic [19:0] addr;   // word address
  logic [15:0] wdata;  // write data
  logic [15:0] rdata;  // captured read data
  logic        done;   // one-cycle pulse at end
  modport master (output req, wr, addr, wdata, input rdata, done);
  modport engine (input req, wr, addr, wdata, output rdata, done);
endinterface : fsc_cyc_if

// file: logic/fsc_pin_cycle.sv
// one asynchronous flash bus cycle on the parallel pins
`timescale 1ns/1ps
module fsc_pin_cycle
  import fsc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // request side
  fsc_cyc_if.engine        cyc,
  // flash pins
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [19:0]      addr,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic             dq_oe
);
  typedef enum logic [3:0] {
    PC_IDLE   = 4'b0001,
    PC_SETUP  = 4'b0010,
    PC_STROBE = 4'b0100,
    PC_HOLD   = 4'b1000
  } fsc_pc_e;
  fsc_pc_e     st, next_st;      // cycle state
  logic [3:0]  cnt, next_cnt;    // phase timer
  logic        wr, next_wr;      // latched direction
  logic [15:0] rd, next_rd;      // captured data
  logic [19:0] next_addr;
  logic [15:0] next_dq_out;
  logic        next_ce_n, next_oe_n, next_we_n, next_dq_oe;
  logic        done_r, next_done;

  assign cyc.rdata = rd;
  assign cyc.done  = done_r;

  // next state: both enables low only during the strobe phase
  always_comb begin
    next_st = st; next_cnt = cnt; next_wr = wr; next_rd = rd;
    next_addr = addr; next_dq_out = dq_out; next_done = 1'b0;
    next_ce_n = ce_n; next_oe_n = oe_n; next_we_n = we_n;
    next_dq_oe = dq_oe;
    case (st)
      PC_IDLE: begin
        if (cyc.req) begin
          next_st = PC_SETUP; next_cnt = PHASE_CNT;
          next_wr = cyc.wr; next_addr = cyc.addr;
          next_dq_out = cyc.wdata; next_dq_oe = cyc.wr;
          next_ce_n = 1'b0;
        end
      end
      PC_SETUP: begin
        if (cnt == 4'h0) begin
          next_st = PC_STROBE; next_cnt = PHASE_CNT;
          next_we_n = ~wr;  // write taken only with ce and we low
          next_oe_n = wr;
        end else next_cnt = cnt - 4'h1;
      end
      PC_STROBE: begin
        if (cnt == 4'h0) begin
          next_st = PC_HOLD; next_cnt = PHASE_CNT;
          next_we_n = 1'b1; next_oe_n = 1'b1;
          if (!wr) next_rd = dq_in;
        end else next_cnt = cnt - 4'h1;
      end
      PC_HOLD: begin
        if (cnt == 4'h0) begin
          next_st = PC_IDLE; next_ce_n = 1'b1;
          next_dq_oe = 1'b0; next_done = 1'b1;
        end else next_cnt = cnt - 4'h1;
      end
      default: next_st = PC_IDLE;
    endcase
  end

  // registers; writes blocked by holding ce and we high at rest
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= PC_IDLE; cnt <= 4'h0; wr <= 1'b0; rd <= 16'h0000;
      addr <= 20'h00000; dq_out <= 16'h0000; dq_oe <= 1'b0;
      ce_n <= 1'b1; oe_n <= 1'b1; we_n <= 1'b1; done_r <= 1'b0;
    end else begin
      st <= next_st; cnt <= next_cnt; wr <= next_wr; rd <= next_rd;
      addr <= next_addr; dq_out <= next_dq_out; dq_oe <= next_dq_oe;
      ce_n <= next_ce_n; oe_n <= next_oe_n; we_n <= next_we_n;
      done_r <= next_done;
    end
  end

  AST_WE_WITH_CE: assert property (@(posedge clk) disable iff (!rst_n)
    !we_n |-> !ce_n) else $error("we low without ce");
  AST_NO_WRITE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    (st == PC_IDLE) |-> we_n && ce_n) else $error("strobe at rest");
endmodule : fsc_pin_cycle

// file: logic/fsc_pkg.sv
// shared constants for the flash status and protection controller
package fsc_pkg;
  // wishbone register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RESULT = 8'h10;
  // control register fields
  localparam int CTRL_OP_LSB  = 0;  // operation code, 3 bits
  localparam int CTRL_GO_BIT  = 4;  // write one to start
  localparam int CTRL_RST_BIT = 8;  // drive reset/power-down low
  localparam int CTRL_WP_BIT  = 9;  // drive write-protect low
  // operations
  localparam logic [2:0] OP_READ_STATUS = 3'h0;
  localparam logic [2:0] OP_CLEAR       = 3'h1;
  localparam logic [2:0] OP_READ_ARRAY  = 3'h2;
  localparam logic [2:0] OP_CLEAR_LOCKS = 3'h3;
  localparam logic [2:0] OP_SET_LOCK    = 3'h4;
  localparam logic [2:0] OP_ERASE       = 3'h5;
  localparam logic [2:0] OP_WRITE       = 3'h6;
  localparam logic [2:0] OP_READ_WORD   = 3'h7;
  // flash command codes
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR       = 8'h50;
  localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET    = 8'h01;
  localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  // status bit positions
  localparam int SR_READY  = 7;
  localparam int SR_ERASE  = 5;
  localparam int SR_WRITE  = 4;
  localparam int SR_SUPPLY = 3;
  localparam int SR_PROT   = 1;
  // pin timing: each strobe phase 100 ns rounded up to 13 clocks, held 14 clocks (112 ns)
  localparam int PHASE_NS     = 100;
  localparam int CLK_NS       = 8;
  localparam int PHASE_CYC    = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PHASE_CNT = 4'(PHASE_CYC);
  // result register error codes
  localparam logic [1:0] RES_OK    = 2'h0;
  localparam logic [1:0] RES_ERROR = 2'h1;
endpackage : fsc_pkg

// file: test/fsc_flash_model.sv
// behavioural flash device facing the controller pins
`timescale 1ns/1ps
module fsc_flash_model
  import fsc_pkg::*;
#(
  parameter int BUSY_CYC = 20,  // internal machine run time
  parameter int RST_CYC  = 6    // abort time once reset lands
) (
  // timing clock
  input  wire logic        clk,
  // control pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rp_n,
  input  wire logic        wp_n,
  // address and data
  input  wire logic [19:0] addr,
  input  wire logic [15:0] din,
  output logic [15:0]      dout,
  output logic             rb_low,
  // bench knobs
  input  wire logic        supply_ok,
  input  wire logic        fail_clear,
  input  wire logic        perm_lock
);
  logic [7:0]  sr        = 8'h80;   // status register
  logic [15:0] mem [16];            // four blocks of four words
  logic [3:0]  lock      = 4'h0;    // block lock bits
  logic        stat_mode = 1'b0;    // reads return status
  logic [7:0]  setup     = 8'h00;   // pending setup command
  logic [15:0] last      = 16'h0;   // last value driven
  logic        prev_we   = 1'b1;    // write strobe one edge ago
  int          busy      = 0;       // machine cycles left
  int          hold      = 0;       // reset abort cycles left
  logic [7:0]  e;                   // error bits of a confirm
  wire  [1:0]  blk   = addr[3:2];
  wire         guard = lock[blk] | (~wp_n & ~blk[1]);
  wire         drv   = ~ce_n & ~oe_n & rp_n;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  // released bus shows the inverse of the last value
  assign dout = drv ? (stat_mode ? {8'h00, sr} : mem[addr[3:0]]) : ~last;
  // open drain: pull-up wins whenever the pin floats
  assign rb_low = (busy > 0) | (hold > 0);
  // error bits of the confirm now on the bus
  always_comb begin
    e = 8'h30;
    if (setup == CMD_LOCK_SETUP && din[7:0] == CMD_CONFIRM)
      e = perm_lock ? 8'h22 : !supply_ok ? 8'h28 : fail_clear ? 8'h20 : 8'h00;
    else if (setup == CMD_LOCK_SETUP && din[7:0] == CMD_LOCK_SET)
      e = perm_lock ? 8'h12 : !supply_ok ? 8'h18 : 8'h00;
    else if (setup == CMD_ERASE_SETUP && din[7:0] == CMD_CONFIRM)
      e = !supply_ok ? 8'h28 : guard ? 8'h22 : 8'h00;
    else if (setup == CMD_WRITE_SETUP)
      e = !supply_ok ? 8'h18 : guard ? 8'h12 : 8'h00;
  end
  // command latch, machine timing and reset
  always @(posedge clk) begin
    prev_we <= we_n;
    if (drv) last <= dout;
    if (!rp_n) begin
      sr <= 8'h80;
      stat_mode <= 1'b0;
      setup <= 8'h00;
      busy <= 0;
      if (busy > 0) hold <= RST_CYC;
      else if (hold > 0) hold <= hold - 1;
    end else begin
      hold <= 0;
      if (busy > 0) begin
        busy <= busy - 1;
        if (busy == 1) sr[7] <= 1'b1;
      end else if (!prev_we && we_n && !ce_n) begin
        if (setup != 8'h00) begin
          setup <= 8'h00;
          busy <= BUSY_CYC;
          sr <= {1'b0, sr[6:0] | e[6:0]};
          if (e == 8'h00) begin
            case (setup)
              CMD_LOCK_SETUP: begin
                if (din[7:0] == CMD_CONFIRM) lock <= 4'h0;
                else lock[blk] <= 1'b1;
              end
              CMD_ERASE_SETUP: begin
                for (int i = 0; i < 4; i++) mem[{blk, 2'(i)}] <= 16'hffff;
              end
              default: mem[addr[3:0]] <= din;
            endcase
          end
        end else begin
          case (din[7:0])
            CMD_READ_ARRAY:  stat_mode <= 1'b0;
            CMD_READ_STATUS: stat_mode <= 1'b1;
            CMD_CLEAR:       sr <= 8'h80;
            CMD_LOCK_SETUP, CMD_ERASE_SETUP, CMD_WRITE_SETUP: begin
              setup <= din[7:0];
              stat_mode <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule : fsc_flash_model

// file: test/tb.sv
// self-checking bench for the flash controller
`timescale 1ns/1ps
module tb;
  import fsc_pkg::*;
  logic        CORE_CLK   = 1'b0;
  logic        RST_N      = 1'b0;
  logic        cyc        = 1'b0;   // wishbone request
  logic        stb        = 1'b0;
  logic        we         = 1'b0;
  logic [7:0]  adr        = 8'h00;
  logic [31:0] wdat       = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        ce_n, oe_n, we_n, rp_n, wp_n;  // flash pins
  logic [19:0] fl_addr;
  logic [15:0] dq_o, dq_m;
  logic        dq_oe, rb_low;
  logic        supply_ok  = 1'b1;   // device knobs
  logic        fail_clear = 1'b0;
  logic        perm_lock  = 1'b0;
  logic [1:0]  ctl_hi     = 2'b11;  // write protect, reset hold
  logic [31:0] rd;                  // last read data
  int          errors     = 0;
  int          cmp_count  = 0;
  always #4 CORE_CLK = ~CORE_CLK;
  fsc_ctrl fsc_ctrl_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_SEL_I(4'hf), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .RESET_POWERDOWN_IN_N(rp_n),
    .WP_N(wp_n), .READY_BUSY_OUT(~rb_low), .FL_ADDR(fl_addr),
    .DQ_I(dq_oe ? dq_o : dq_m), .DQ_O(dq_o), .DQ_OE(dq_oe));
  fsc_flash_model fsc_flash_model_inst (.clk(CORE_CLK), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .wp_n(wp_n), .addr(fl_addr),
    .din(dq_o), .dout(dq_m), .rb_low(rb_low), .supply_ok(supply_ok),
    .fail_clear(fail_clear), .perm_lock(perm_lock));
  // verdict and end of run
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rd = rdat;
    if (ack !== 1'b1) errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // compare one value
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // status byte with ready pin high
  task automatic st(input logic [7:0] x);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", {23'h0, 1'b1, x}, {23'h0, rd[8:0]});
  endtask : st
  // reset hold and write protect bits
  task automatic ctl(input logic [1:0] v);
    ctl_hi = v;
    wb(1'b1, REG_CTRL, {22'h0, v, 8'h00});
  endtask : ctl
  // start one operation and poll busy under a bound
  task automatic op(input logic [2:0] c, input logic [19:0] a, input logic [15:0] d);
    int n;
    wb(1'b1, REG_ADDR, {12'h0, a});
    wb(1'b1, REG_DATA, {16'h0, d});
    wb(1'b1, REG_CTRL, {22'h0, ctl_hi, 3'h0, 1'b1, 1'b0, c});
    n = 0;
    do begin
      wb(1'b0, REG_CTRL, 32'h0);
      n++;
    end while (rd[5] !== 1'b0 && n < 3000);
    if (rd[5] !== 1'b0) errors++;
  endtask : op
  // read one array word
  task automatic word(input logic [19:0] a, input logic [15:0] x);
    op(OP_READ_WORD, a, 16'h0);
    wb(1'b0, REG_DATA, 32'h0);
    chk("word", {16'h0, x}, {16'h0, rd[15:0]});
  endtask : word
  // watchdog well past the expected run
  initial begin
    #480000;
    errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    ctl(2'b00);
    op(OP_READ_STATUS, 20'h0, 16'h0);
    st(8'h80);
    op(OP_WRITE, 20'h8, 16'h1234);
    st(8'h80);
    word(20'h8, 16'h1234);
    $display("test write done");
    op(OP_SET_LOCK, 20'h8, 16'h0);
    op(OP_WRITE, 20'h8, 16'h5555);
    st(8'h92);
    wb(1'b0, REG_RESULT, 32'h0);
    chk("result", 32'(RES_ERROR), {30'h0, rd[1:0]});
    word(20'h8, 16'h1234);
    op(OP_READ_STATUS, 20'h0, 16'h0);
    st(8'h92);
    op(OP_CLEAR, 20'h0, 16'h0);
    op(OP_READ_STATUS, 20'h0, 16'h0);
    st(8'h80);
    $display("test lock done");
    fail_clear <= 1'b1;
    op(OP_CLEAR_LOCKS, 20'h0, 16'h0);
    st(8'ha0);
    op(OP_CLEAR, 20'h0, 16'h0);
    fail_clear <= 1'b0;
    op(OP_CLEAR_LOCKS, 20'h0, 16'h0);
    st(8'h80);
    op(OP_WRITE, 20'h8, 16'h5555);
    word(20'h8, 16'h5555);
    $display("test unlock done");
    ctl(2'b10);
    op(OP_WRITE, 20'h4, 16'h0a0a);
    st(8'h92);
    op(OP_CLEAR, 20'h0, 16'h0);
    op(OP_WRITE, 20'hc, 16'h0b0b);
    st(8'h80);
    $display("test protect done");
    supply_ok <= 1'b0;
    op(OP_ERASE, 20'hc, 16'h0);
    st(8'ha8);
    op(OP_CLEAR, 20'h0, 16'h0);
    op(OP_WRITE, 20'hc, 16'h7777);
    st(8'h98);
    ctl(2'b01);
    ctl(2'b00);
    supply_ok <= 1'b1;
    word(20'hc, 16'h0b0b);
    op(OP_READ_STATUS, 20'h0, 16'h0);
    st(8'h80);
    op(OP_READ_ARRAY, 20'h0, 16'h0);
    word(20'hc, 16'h0b0b);
    $display("test supply done");
    perm_lock <= 1'b1;
    op(OP_SET_LOCK, 20'hc, 16'h0);
    st(8'h92);
    op(OP_CLEAR, 20'h0, 16'h0);
    op(OP_CLEAR_LOCKS, 20'h0, 16'h0);
    st(8'ha2);
    $display("test permanent done");
    end_of_test();
  end
endmodule : tb
